/* File: logic/backplane_map.svh */
// offsets, codes and timing counts for the backplane slot link
`ifndef BACKPLANE_MAP_SVH
`define BACKPLANE_MAP_SVH
`define BP_CORE_PERIOD_NS 50
`define BP_BUS_PERIOD_NS 200
`define BP_CLK_DIV (`BP_BUS_PERIOD_NS / `BP_CORE_PERIOD_NS)
`define BP_RW_READ 1'b1
`define BP_RW_WRITE 1'b0
`define BP_MODE_NORMAL 1'b1
`define BP_MODE_SYSTEM 1'b0
`define BP_WIDTH_BYTE 2'b11
`define BP_WIDTH_WORD 2'b01
`define BP_WIDTH_LONG 2'b00
`define BP_OD_WAIT 0
`define BP_OD_STOP 1
`define BP_OD_BUS_REQUEST_N 2
`define BP_OD_IRQ_LEVEL_ONE_N 3
`define BP_OD_IRQ_LEVEL_TWO_N 4
`define BP_OD_IRQ_LEVEL_THREE_N 5
`define BP_OD_SHARED_RESOURCE_REQ_N 6
`define BP_OD_LINES 7
`define BP_WAIT_STATES 2
`define BP_SLOT_BASE 32'h0000_1000
`define BP_SLOT_WORDS 16
`endif

/* File: logic/bp_pkg.sv */
// types and shared helpers for the backplane slot link
`include "backplane_map.svh"
package bp_pkg;
  typedef enum logic [2:0] {M_IDLE, M_ADDR, M_ADDR_END, M_DATA, M_DWAIT, M_END, M_GRANTED}
    master_state_t;
  typedef logic [1:0] width_code_t;

  // byte lanes touched by an access of the given width at the given address
  function automatic logic [3:0] lane_mask(input width_code_t code, input logic [1:0] a);
    logic [3:0] m;
    m = 4'hf;
    if (code == `BP_WIDTH_BYTE) begin
      m = 4'h1 << a;
    end else if (code == `BP_WIDTH_WORD) begin
      m = a[1] ? 4'hc : 4'h3;
    end
    return m;
  endfunction : lane_mask
endpackage : bp_pkg

/* File: logic/backplane_if.sv */
// backplane carrier joining the cpu board end and one slot module
`timescale 1ns/10ps
`include "backplane_map.svh"
interface backplane_if;
  logic bus_clk;
  logic sys_reset_n;
  logic read_write;
  logic normal_mode;
  logic byte_word_sel;
  logic word_long_select;
  logic addr_strobe_n;
  logic data_strobe_n;
  logic [31:0] ad_m_o;
  logic ad_m_oe;
  logic [31:0] ad_s_o;
  logic ad_s_oe;
  logic [31:0] ad;
  logic [`BP_OD_LINES-1:0] od_o;
  logic [`BP_OD_LINES-1:0] od_oe;
  logic [`BP_OD_LINES-1:0] od_n;
  logic bus_grant_in_n;
  logic bus_grant_out_n;
  logic ack_chain_in_l1;
  logic ack_chain_in_l2;
  logic ack_chain_in_l3;
  logic ack_chain_out_l1;
  logic ack_chain_out_l2;
  logic ack_chain_out_l3;
  logic resource_grant_in_n;
  logic resource_grant_out;
  logic power_fail_warn_n;

  // shared lines: master wins, idle lines float high through pull-ups
  assign ad = ad_m_oe ? ad_m_o : (ad_s_oe ? ad_s_o : 32'hffff_ffff);
  assign od_n = od_o | ~od_oe;
  // multi-cpu sharing lines ride on the carrier: one shared resource request line and the resource grant chain

  modport master (
    output bus_clk, sys_reset_n, read_write, normal_mode, byte_word_sel, word_long_select,
    output addr_strobe_n, data_strobe_n, ad_m_o, ad_m_oe, bus_grant_in_n,
    output ack_chain_in_l1, ack_chain_in_l2, ack_chain_in_l3, resource_grant_in_n,
    output power_fail_warn_n,
    input ad, od_n, bus_grant_out_n, ack_chain_out_l1, ack_chain_out_l2, ack_chain_out_l3,
    input resource_grant_out
  );
  modport slot (
    input bus_clk, sys_reset_n, read_write, normal_mode, byte_word_sel, word_long_select,
    input addr_strobe_n, data_strobe_n, ad, od_n, bus_grant_in_n,
    input ack_chain_in_l1, ack_chain_in_l2, ack_chain_in_l3, resource_grant_in_n,
    input power_fail_warn_n,
    output ad_s_o, ad_s_oe, od_o, od_oe, bus_grant_out_n,
    output ack_chain_out_l1, ack_chain_out_l2, ack_chain_out_l3, resource_grant_out
  );
endinterface : backplane_if

/* File: logic/backplane_master.sv */
// cpu board end: bus clock maker, transfer sequencer and arbiter heads
`timescale 1ns/10ps
`include "backplane_map.svh"
module backplane_master #(
  parameter int unsigned CLK_DIV = `BP_CLK_DIV
) (
  input wire logic core_clk, // master clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable
  backplane_if.master bp, // backplane side
  input wire logic req, // start a transfer (level)
  input wire logic req_read, // 1 read, 0 write
  input wire logic req_system, // 1 system mode access
  input wire logic [1:0] req_width, // byte/word/long code
  input wire logic [31:0] req_addr, // address
  input wire logic [31:0] req_wdata, // write data
  input wire logic power_bad_n, // supply warning pin, async
  output logic busy, // transfer or grant in progress
  output logic done, // transfer finished (pulse)
  output logic null_cycle, // last transfer was a null one
  output logic [31:0] rdata, // read data of last transfer
  output logic granted_away, // bus lent to a module
  output logic [2:0] irq_pending // levels 3..1 requested
);
  localparam logic [3:0] HALF = 4'(CLK_DIV / 2);
  localparam logic [3:0] LAST = 4'(CLK_DIV - 1);

  if (CLK_DIV < 4 || CLK_DIV > 16 || (CLK_DIV % 2) != 0) begin : g_bad_div
    $error("CLK_DIV must be even and within 4..16");
  end

  bp_pkg::master_state_t state_q;
  logic [3:0] phase_q;
  logic bus_clk_q, tick, rst_seen_q;
  logic sys_reset_n_q, rw_q, mode_q, bw_q, wl_q, as_n_q, ds_n_q, ad_oe_q;
  logic [31:0] ad_o_q, ad_s1_q, ad_s2_q, rdata_q;
  logic [`BP_OD_LINES-1:0] od_s1_q, od_s2_q;
  logic pw_s1_q, pw_s2_q, pw_q;
  logic grant_n_q, res_grant_n_q, head_q;
  logic done_q, null_q, busy_q, away_q;
  logic [2:0] irq_q;

  // first cycle of a reset seen, so the divider is cleared only once
  always_ff @(posedge core_clk) begin
    rst_seen_q <= rst;
  end

  // bus clock is the master clock divided down; a quarter by default
  // keeps running through reset, else the slot never sees the reset line low
  always_ff @(posedge core_clk) begin
    if ((rst && rst_seen_q) || (!rst && ce)) begin
      phase_q <= (phase_q == LAST) ? 4'h0 : phase_q + 4'h1;
      bus_clk_q <= (phase_q == LAST) || (phase_q < HALF - 4'h1);
    end else if (rst) begin
      phase_q <= 4'h0;
      bus_clk_q <= 1'b0;
    end
  end
  // bus outputs move one master clock after the falling bus clock edge
  assign tick = ce && (phase_q == HALF);

  // slot lines cross from the bus clock domain and the supply pin is async
  always_ff @(posedge core_clk) begin
    od_s1_q <= bp.od_n;
    od_s2_q <= od_s1_q;
    ad_s1_q <= bp.ad;
    ad_s2_q <= ad_s1_q;
    pw_s1_q <= power_bad_n;
    pw_s2_q <= pw_s1_q;
  end

  // system reset line, chain heads and warning line; bus lines move on tick
  // only, never on the edge where the slot samples them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sys_reset_n_q <= 1'b0;
      head_q <= 1'b0;
      res_grant_n_q <= 1'b1;
      pw_q <= 1'b1;
      irq_q <= 3'h0;
    end else if (ce) begin
      if (tick) begin
        sys_reset_n_q <= 1'b1;
        head_q <= 1'b1;
        res_grant_n_q <= od_s2_q[`BP_OD_SHARED_RESOURCE_REQ_N];
        pw_q <= pw_s2_q;
      end
      irq_q <= ~od_s2_q[`BP_OD_IRQ_LEVEL_THREE_N:`BP_OD_IRQ_LEVEL_ONE_N];
    end
  end

  // transfer sequencer and bus grant
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= bp_pkg::M_IDLE;
      as_n_q <= 1'b1;
      ds_n_q <= 1'b1;
      ad_oe_q <= 1'b0;
      ad_o_q <= 32'h0000_0000;
      rw_q <= `BP_RW_READ;
      mode_q <= `BP_MODE_SYSTEM;
      bw_q <= 1'b1;
      wl_q <= 1'b1;
      grant_n_q <= 1'b1;
      done_q <= 1'b0;
      null_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (ce) begin
      done_q <= 1'b0;
      if (tick) begin
        case (state_q)
          bp_pkg::M_IDLE: begin
            if (!od_s2_q[`BP_OD_BUS_REQUEST_N]) begin
              grant_n_q <= 1'b0;
              ad_oe_q <= 1'b0;
              state_q <= bp_pkg::M_GRANTED;
            end else if (req) begin
              as_n_q <= 1'b0;
              ad_o_q <= req_addr;
              ad_oe_q <= 1'b1;
              rw_q <= req_read;
              mode_q <= req_system ? `BP_MODE_SYSTEM : `BP_MODE_NORMAL;
              {bw_q, wl_q} <= req_width;
              state_q <= bp_pkg::M_ADDR;
            end
          end
          bp_pkg::M_ADDR: begin
            as_n_q <= 1'b1; // rising edge marks address valid
            state_q <= bp_pkg::M_ADDR_END;
          end
          bp_pkg::M_ADDR_END: begin
            null_q <= !od_s2_q[`BP_OD_STOP];
            ds_n_q <= !od_s2_q[`BP_OD_STOP];
            ad_o_q <= req_wdata;
            ad_oe_q <= (rw_q == `BP_RW_WRITE);
            state_q <= bp_pkg::M_DATA;
          end
          bp_pkg::M_DATA: begin
            // one spare tick lets the slot's wait pull cross over first
            state_q <= bp_pkg::M_DWAIT;
          end
          bp_pkg::M_DWAIT: begin
            if (od_s2_q[`BP_OD_WAIT]) begin
              rdata_q <= ad_s2_q;
              ds_n_q <= 1'b1;
              ad_oe_q <= 1'b0;
              done_q <= 1'b1;
              state_q <= bp_pkg::M_END;
            end
          end
          bp_pkg::M_END: begin
            state_q <= bp_pkg::M_IDLE;
          end
          bp_pkg::M_GRANTED: begin
            if (od_s2_q[`BP_OD_BUS_REQUEST_N]) begin
              grant_n_q <= 1'b1;
              state_q <= bp_pkg::M_IDLE;
            end
          end
          default: state_q <= bp_pkg::M_IDLE;
        endcase
      end
    end
  end

  // user status flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      away_q <= 1'b0;
    end else if (ce) begin
      busy_q <= (state_q != bp_pkg::M_IDLE);
      away_q <= (state_q == bp_pkg::M_GRANTED);
    end
  end

  assign bp.bus_clk = bus_clk_q;
  assign bp.sys_reset_n = sys_reset_n_q;
  assign bp.read_write = rw_q;
  assign bp.normal_mode = mode_q;
  assign bp.byte_word_sel = bw_q;
  assign bp.word_long_select = wl_q;
  assign bp.addr_strobe_n = as_n_q;
  assign bp.data_strobe_n = ds_n_q;
  assign bp.ad_m_o = ad_o_q;
  assign bp.ad_m_oe = ad_oe_q;
  assign bp.bus_grant_in_n = grant_n_q;
  assign bp.ack_chain_in_l1 = head_q;
  assign bp.ack_chain_in_l2 = head_q;
  assign bp.ack_chain_in_l3 = head_q;
  assign bp.resource_grant_in_n = res_grant_n_q;
  assign bp.power_fail_warn_n = pw_q;
  assign busy = busy_q;
  assign done = done_q;
  assign null_cycle = null_q;
  assign rdata = rdata_q;
  assign granted_away = away_q;
  assign irq_pending = irq_q;
endmodule : backplane_master

/* File: logic/backplane_slot.sv */
// slot module end: memory-window slave, requester and chain member
`timescale 1ns/10ps
`include "backplane_map.svh"
module backplane_slot #(
  parameter int unsigned WAIT_STATES = `BP_WAIT_STATES,
  parameter logic [31:0] BASE_ADDR = `BP_SLOT_BASE,
  parameter int unsigned MEM_WORDS = `BP_SLOT_WORDS,
  parameter bit SYSTEM_ONLY = 1'b0
) (
  input wire logic core_clk, // local clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable
  backplane_if.slot bp, // backplane side, clocked by bus_clk
  input wire logic [2:0] irq_req, // interrupt levels 3..1 wanted
  input wire logic bus_req, // wants bus mastership
  input wire logic res_req, // wants the shared resource
  input wire logic epu_stop, // extended processing unit stop
  output logic bus_owned, // bus granted to this slot
  output logic res_owned, // shared resource granted
  output logic [2:0] irq_selected, // chain picks this slot, per level
  output logic power_warn // supply about to fail
);
  localparam int unsigned IDX_W = $clog2(MEM_WORDS);
  localparam logic [31:0] WIN_MASK = 32'(MEM_WORDS * 4 - 1);
  localparam logic [7:0] WAIT_INIT = 8'(WAIT_STATES);

  if (MEM_WORDS < 2 || MEM_WORDS > 4096 || (MEM_WORDS & (MEM_WORDS - 1)) != 0)
  begin : g_bad_words
    $error("MEM_WORDS must be a power of two within 2..4096");
  end
  if (WAIT_STATES > 255 || (BASE_ADDR & WIN_MASK) != 32'h0000_0000) begin : g_bad_cfg
    $error("WAIT_STATES above 255 or BASE_ADDR not aligned to the window");
  end

  logic [1:0] rst_sync_q;
  logic brst, ce_b, complete, hit;
  logic [6:0] usr_s1_q, usr_s2_q;
  logic [2:0] irq_s;
  logic bus_req_s, res_req_s, stop_s;
  logic [5:0] req_oe_q;
  logic grant_out_n_q, res_out_q;
  logic [2:0] ack_out_q, ack_in;
  logic [5:0] stat_q, stat_s1_q, stat_s2_q, out_q;
  logic as_prev_q, ds_prev_q, sel_q, rw_q, busy_q, wait_oe_q, ad_oe_q;
  logic [7:0] wait_cnt_q;
  logic [IDX_W-1:0] idx_q;
  logic [3:0] lanes_q;
  logic [31:0] ad_q;
  logic [31:0] mem [MEM_WORDS];

  // bus-side reset follows the backplane reset line
  always_ff @(posedge bp.bus_clk) begin
    rst_sync_q <= {rst_sync_q[0], ~bp.sys_reset_n | rst};
  end
  assign brst = rst_sync_q[1];

  // user requests come from the local clock, so they cross by two flops
  always_ff @(posedge bp.bus_clk) begin
    usr_s1_q <= {ce, epu_stop, res_req, bus_req, irq_req};
    usr_s2_q <= usr_s1_q;
  end
  assign irq_s = usr_s2_q[2:0];
  assign bus_req_s = usr_s2_q[3];
  assign res_req_s = usr_s2_q[4];
  assign stop_s = usr_s2_q[5];
  assign ce_b = usr_s2_q[6];
  assign ack_in = {bp.ack_chain_in_l3, bp.ack_chain_in_l2, bp.ack_chain_in_l1};

  // open-drain requests and chain members; chains are registered on bus_clk
  always_ff @(posedge bp.bus_clk) begin
    if (brst) begin
      req_oe_q <= 6'h00;
      grant_out_n_q <= 1'b1;
      ack_out_q <= 3'h0;
      res_out_q <= 1'b0;
    end else if (ce_b) begin
      req_oe_q[0] <= stop_s;
      req_oe_q[1] <= bus_req_s;
      req_oe_q[4:2] <= irq_s;
      req_oe_q[5] <= res_req_s;
      grant_out_n_q <= bp.bus_grant_in_n | bus_req_s;
      ack_out_q <= ack_in & ~irq_s;
      res_out_q <= ~bp.resource_grant_in_n & ~res_req_s;
    end
  end

  // status as seen on the bus clock, handed to the local side
  always_ff @(posedge bp.bus_clk) begin
    if (brst) begin
      stat_q <= 6'h00;
    end else if (ce_b) begin
      stat_q[0] <= req_oe_q[1] & ~bp.bus_grant_in_n;
      stat_q[1] <= req_oe_q[5] & ~bp.resource_grant_in_n;
      stat_q[4:2] <= ack_in & req_oe_q[4:2];
      stat_q[5] <= ~bp.power_fail_warn_n;
    end
  end

  // address phase decode: window hit and privilege check
  assign hit = ((bp.ad & ~WIN_MASK) == BASE_ADDR) &&
               !(SYSTEM_ONLY && bp.normal_mode == `BP_MODE_NORMAL);
  assign complete = busy_q && (wait_cnt_q == 8'h00);

  // slave sequence; wait is pulled until the edge that puts read data on the lanes, so the master
  // never sees a released line before the read data is on the lanes
  always_ff @(posedge bp.bus_clk) begin
    if (brst) begin
      as_prev_q <= 1'b1;
      ds_prev_q <= 1'b1;
      sel_q <= 1'b0;
      rw_q <= `BP_RW_READ;
      idx_q <= '0;
      lanes_q <= 4'h0;
      busy_q <= 1'b0;
      wait_cnt_q <= 8'h00;
      wait_oe_q <= 1'b0;
      ad_q <= 32'h0000_0000;
      ad_oe_q <= 1'b0;
    end else if (ce_b) begin
      as_prev_q <= bp.addr_strobe_n;
      ds_prev_q <= bp.data_strobe_n;
      if (!as_prev_q && bp.addr_strobe_n) begin
        sel_q <= hit;
        rw_q <= bp.read_write;
        idx_q <= bp.ad[IDX_W+1:2];
        lanes_q <= bp_pkg::lane_mask({bp.byte_word_sel, bp.word_long_select},
                                     bp.ad[1:0]);
      end
      if (bp.data_strobe_n) begin
        ad_oe_q <= 1'b0; // lanes freed once the strobe ends
      end
      if (ds_prev_q && !bp.data_strobe_n && sel_q) begin
        busy_q <= 1'b1;
        wait_oe_q <= 1'b1;
        wait_cnt_q <= WAIT_INIT;
      end else if (busy_q && wait_cnt_q != 8'h00) begin
        wait_cnt_q <= wait_cnt_q - 8'h01;
      end else if (complete) begin
        busy_q <= 1'b0;
        wait_oe_q <= 1'b0;
        if (rw_q == `BP_RW_READ) begin
          ad_q <= mem[idx_q];
          ad_oe_q <= 1'b1;
        end
      end
    end
  end

  // storage write, byte lanes merged; no reset so it can map to ram
  always_ff @(posedge bp.bus_clk) begin
    if (!brst && ce_b && complete && rw_q == `BP_RW_WRITE) begin
      for (int b = 0; b < 4; b++) begin
        if (lanes_q[b]) begin
          mem[idx_q][b*8 +: 8] <= bp.ad[b*8 +: 8];
        end
      end
    end
  end

  // local side: status crosses back by two flops, then is held
  always_ff @(posedge core_clk) begin
    stat_s1_q <= stat_q;
    stat_s2_q <= stat_s1_q;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_q <= 6'h00;
    end else if (ce) begin
      out_q <= stat_s2_q;
    end
  end

  assign bp.od_o = '0;
  assign bp.od_oe = {req_oe_q[5], req_oe_q[4:2], req_oe_q[1], req_oe_q[0], wait_oe_q};
  assign bp.ad_s_o = ad_q;
  assign bp.ad_s_oe = ad_oe_q;
  assign bp.bus_grant_out_n = grant_out_n_q;
  assign bp.ack_chain_out_l1 = ack_out_q[0];
  assign bp.ack_chain_out_l2 = ack_out_q[1];
  assign bp.ack_chain_out_l3 = ack_out_q[2];
  assign bp.resource_grant_out = res_out_q;
  assign bus_owned = out_q[0];
  assign res_owned = out_q[1];
  assign irq_selected = out_q[4:2];
  assign power_warn = out_q[5];
endmodule : backplane_slot

/* File: sim/backplane_properties.sv */
// concurrent checks on the carrier between the cpu board end and the slot
`timescale 1ns/10ps
`include "backplane_map.svh"
module backplane_properties (
  input wire logic core_clk, // master clock
  input wire logic rst, // master reset, active high
  input wire logic bus_clk, // derived bus clock
  input wire logic read_write, // transfer direction
  input wire logic addr_strobe_n, // address strobe
  input wire logic data_strobe_n, // data strobe
  input wire logic ad_m_oe, // master drives ad
  input wire logic ad_s_oe, // slot drives ad
  input wire logic [`BP_OD_LINES-1:0] od_n, // resolved open-drain lines
  input wire logic bus_grant_in_n, // grant chain head
  input wire logic bus_grant_out_n, // grant chain tail
  input wire logic ack_chain_out_l1, // level-one ack chain out
  input wire logic resource_grant_out // resource chain out
);
  // bus lines all move on master clock edges, so one domain covers them
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_clock_ratio: assert property (
    $rose(bus_clk) |-> bus_clk ##1 bus_clk ##1 !bus_clk ##1 !bus_clk ##1 bus_clk)
    else $error("bus clock not a quarter of master clock");
  chk_as_width: assert property (
    $fell(addr_strobe_n) |-> (!addr_strobe_n && data_strobe_n)[*4] ##1 addr_strobe_n)
    else $error("address strobe low time wrong");
  chk_ds_after_as: assert property (
    $fell(data_strobe_n) |-> $past(addr_strobe_n, 4) && !$past(addr_strobe_n, 5))
    else $error("data strobe not one bus clock after address strobe");
  chk_addr_drive: assert property (
    !addr_strobe_n |-> ad_m_oe && !ad_s_oe)
    else $error("address phase not driven by master alone");
  chk_drive_dir: assert property (
    !data_strobe_n |-> (ad_m_oe == !read_write) && (!ad_s_oe || read_write))
    else $error("data direction disagrees with read/write line");
  chk_wait_length: assert property (
    $fell(od_n[0]) |-> !od_n[0][*8] ##1 !od_n[0][*4] ##1 od_n[0])
    else $error("wait line held for wrong time");
  chk_wait_hold: assert property (
    !od_n[0] && !data_strobe_n |=> !data_strobe_n)
    else $error("master left data phase while wait low");
  chk_null_strobe: assert property (
    !od_n[1][*4] |-> !$fell(data_strobe_n))
    else $error("data strobe fell while stop held");
  chk_grant_given: assert property (
    $fell(od_n[2]) |-> ##[1:80] !bus_grant_in_n)
    else $error("bus request never granted");
  chk_grant_block: assert property (
    !od_n[2][*8] |-> bus_grant_out_n)
    else $error("requesting slot passed the grant on");
  chk_ack_chain: assert property (
    !od_n[3][*8] |-> !ack_chain_out_l1)
    else $error("interrupting slot passed level-one ack on");
  chk_resource_block: assert property (
    !od_n[6][*8] |-> !resource_grant_out)
    else $error("requesting slot passed resource grant on");
endmodule : backplane_properties

/* File: sim/tb_backplane_bus_slot_signaling.sv */
// self-checking bench: cpu board end and slot module joined on one carrier
`timescale 1ns/10ps
`include "backplane_map.svh"
module tb_backplane_bus_slot_signaling;
  logic core_clk = 1'b0;
  logic slot_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_read = 1'b0;
  logic req_system = 1'b1;
  logic [1:0] req_width = `BP_WIDTH_LONG;
  logic [31:0] req_addr = 32'h0;
  logic [31:0] req_wdata = 32'h0;
  logic power_bad_n = 1'b1;
  logic [2:0] irq_req = 3'h0;
  logic bus_req = 1'b0;
  logic res_req = 1'b0;
  logic epu_stop = 1'b0;
  logic busy, done, null_cycle, granted_away, bus_owned, res_owned, power_warn;
  logic [31:0] rdata;
  logic [2:0] irq_pending, irq_selected;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  localparam logic [31:0] BASE = `BP_SLOT_BASE;
  localparam int HIT = 18 + 4 * `BP_WAIT_STATES; // earliest edge seeing done, slot hit
  localparam int MISS = 18; // earliest edge seeing done, no wait or null

  // master clock and an unrelated local clock for the slot
  always #25 core_clk = ~core_clk;
  always #16 slot_clk = ~slot_clk;

  backplane_if backplane_if_i ();
  backplane_master backplane_master_i (.core_clk(core_clk), .rst(rst), .ce(1'b1),
    .bp(backplane_if_i.master), .req(req), .req_read(req_read), .req_system(req_system),
    .req_width(req_width), .req_addr(req_addr), .req_wdata(req_wdata),
    .power_bad_n(power_bad_n), .busy(busy), .done(done), .null_cycle(null_cycle),
    .rdata(rdata), .granted_away(granted_away), .irq_pending(irq_pending));
  // system-only slot, so normal-mode accesses must be refused
  backplane_slot #(.SYSTEM_ONLY(1'b1)) backplane_slot_i (.core_clk(slot_clk), .rst(rst),
    .ce(1'b1), .bp(backplane_if_i.slot), .irq_req(irq_req), .bus_req(bus_req),
    .res_req(res_req), .epu_stop(epu_stop), .bus_owned(bus_owned), .res_owned(res_owned),
    .irq_selected(irq_selected), .power_warn(power_warn));
  backplane_properties backplane_properties_i (.core_clk(core_clk), .rst(rst),
    .bus_clk(backplane_if_i.bus_clk), .read_write(backplane_if_i.read_write),
    .addr_strobe_n(backplane_if_i.addr_strobe_n), .data_strobe_n(backplane_if_i.data_strobe_n),
    .ad_m_oe(backplane_if_i.ad_m_oe), .ad_s_oe(backplane_if_i.ad_s_oe),
    .od_n(backplane_if_i.od_n), .bus_grant_in_n(backplane_if_i.bus_grant_in_n),
    .bus_grant_out_n(backplane_if_i.bus_grant_out_n),
    .ack_chain_out_l1(backplane_if_i.ack_chain_out_l1),
    .resource_grant_out(backplane_if_i.resource_grant_out));

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_flag(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_flag

  // one transfer from idle; request held until done, edges to done left in n
  task automatic xfer(input logic rd, input logic sys, input logic [1:0] w,
    input logic [31:0] a, input logic [31:0] d);
    for (n = 0; n == 0 || (busy !== 1'b0 && n < 100); n++)
      @(posedge core_clk);
    req <= 1'b1;
    req_read <= rd;
    req_system <= sys;
    req_width <= w;
    req_addr <= a;
    req_wdata <= d;
    for (n = 1; n < 300; n++) begin
      @(posedge core_clk);
      if (done === 1'b1) break;
    end
    cmp_flag("transfer done", 1'b1, done);
    cmp_flag("busy with done", 1'b1, busy);
    req <= 1'b0;
  endtask : xfer

  // widths, lanes, wait states, mode and window refusals
  task automatic t_access;
    xfer(1'b0, 1'b1, `BP_WIDTH_LONG, BASE, 32'h1234_5678);
    cmp_flag("wait latency", 1'b1, n >= HIT && n <= HIT + 3);
    xfer(1'b0, 1'b1, `BP_WIDTH_BYTE, BASE + 32'h1, 32'h0000_ab00);
    xfer(1'b0, 1'b1, `BP_WIDTH_WORD, BASE + 32'h2, 32'hbeef_0000);
    xfer(1'b1, 1'b1, `BP_WIDTH_LONG, BASE + 32'h3, 32'h0);
    cmp_word("long read", 32'hbeef_ab78, rdata);
    xfer(1'b1, 1'b0, `BP_WIDTH_LONG, BASE, 32'h0);
    cmp_word("normal-mode read", 32'hffff_ffff, rdata);
    cmp_flag("refused latency", 1'b1, n >= MISS && n <= MISS + 3);
    xfer(1'b1, 1'b1, `BP_WIDTH_LONG, BASE + 4 * `BP_SLOT_WORDS, 32'h0);
    cmp_word("unmapped read", 32'hffff_ffff, rdata);
  endtask : t_access

  // a write issued under stop must not land
  task automatic t_null;
    xfer(1'b0, 1'b1, `BP_WIDTH_LONG, BASE + 32'h8, 32'h0);
    epu_stop <= 1'b1;
    for (n = 0; n < 100 && backplane_if_i.od_n[1] !== 1'b0; n++)
      @(posedge core_clk);
    xfer(1'b0, 1'b1, `BP_WIDTH_LONG, BASE + 32'h8, 32'h5a5a_5a5a);
    cmp_flag("null flag", 1'b1, null_cycle);
    cmp_flag("null latency", 1'b1, n >= MISS && n <= MISS + 3);
    epu_stop <= 1'b0;
    for (n = 0; n < 100 && backplane_if_i.od_n[1] !== 1'b1; n++)
      @(posedge core_clk);
    xfer(1'b1, 1'b1, `BP_WIDTH_LONG, BASE + 32'h8, 32'h0);
    cmp_word("after null", 32'h0, rdata);
    cmp_flag("null flag clear", 1'b0, null_cycle);
  endtask : t_null

  // mastership lent to the slot; a user request waits until it returns
  task automatic t_grant;
    @(posedge core_clk);
    bus_req <= 1'b1;
    for (n = 0; n < 200 && bus_owned !== 1'b1; n++)
      @(posedge core_clk);
    cmp_flag("bus owned", 1'b1, bus_owned);
    cmp_flag("lent away", 1'b1, granted_away);
    cmp_flag("grant blocked", 1'b1, backplane_if_i.bus_grant_out_n);
    req <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      if (done === 1'b1) n++;
    end
    cmp_flag("no transfer while lent", 1'b1, n == 0);
    bus_req <= 1'b0;
    for (n = 0; n < 200 && done !== 1'b1; n++)
      @(posedge core_clk);
    req <= 1'b0;
    cmp_flag("transfer after return", 1'b1, n < 200);
  endtask : t_grant

  // each level alone, then all three together
  task automatic t_irq;
    logic [2:0] lv;
    for (int i = 0; i < 4; i++) begin
      lv = (i == 3) ? 3'b111 : 3'b001 << i;
      @(posedge core_clk);
      irq_req <= lv;
      for (n = 0; n < 200 && (irq_pending !== lv || irq_selected !== lv); n++)
        @(posedge core_clk);
      cmp_word("irq pending", {29'h0, lv}, {29'h0, irq_pending});
      cmp_word("irq selected", {29'h0, lv}, {29'h0, irq_selected});
      irq_req <= 3'h0;
      for (n = 0; n < 200 && irq_pending !== 3'h0; n++)
        @(posedge core_clk);
      cmp_word("irq cleared", 32'h0, {29'h0, irq_pending});
    end
  endtask : t_irq

  task automatic t_resource;
    @(posedge core_clk);
    res_req <= 1'b1;
    for (n = 0; n < 200 && res_owned !== 1'b1; n++)
      @(posedge core_clk);
    cmp_flag("resource owned", 1'b1, res_owned);
    cmp_flag("resource chain blocked", 1'b0, backplane_if_i.resource_grant_out);
    res_req <= 1'b0;
    for (n = 0; n < 200 && res_owned !== 1'b0; n++)
      @(posedge core_clk);
    cmp_flag("resource freed", 1'b0, res_owned);
  endtask : t_resource

  task automatic t_power;
    @(posedge core_clk);
    power_bad_n <= 1'b0;
    for (n = 0; n < 200 && power_warn !== 1'b1; n++)
      @(posedge core_clk);
    cmp_flag("power warning", 1'b1, power_warn);
    power_bad_n <= 1'b1;
    for (n = 0; n < 200 && power_warn !== 1'b0; n++)
      @(posedge core_clk);
    cmp_flag("power warning gone", 1'b0, power_warn);
  endtask : t_power

  // second reset in mid-run with an interrupt still wanted
  task automatic t_reset;
    @(posedge core_clk);
    irq_req <= 3'b001;
    for (n = 0; n < 200 && irq_pending !== 3'b001; n++)
      @(posedge core_clk);
    rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    cmp_flag("system reset low", 1'b0, backplane_if_i.sys_reset_n);
    cmp_flag("slot lines released", 1'b1, backplane_if_i.od_n[3]);
    cmp_word("pending cleared", 32'h0, {29'h0, irq_pending});
    irq_req <= 3'h0;
    rst <= 1'b0;
    repeat (16) @(posedge core_clk);
  endtask : t_reset

  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard, well above the several hundred cycles the run needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (16) @(posedge core_clk);
    t_access();
    t_null();
    t_grant();
    t_irq();
    t_resource();
    t_power();
    t_reset();
    tally_and_finish();
  end
endmodule : tb_backplane_bus_slot_signaling
